//--- include/tw_pkg.sv
`default_nettype none
package tw_pkg;

    // ------------------------------------------------------------
    // Addressing
    // ------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDRESS_RESET = 7'h36;
    localparam logic [7:0] TOP_ADDRESS = 8'hFF;
    localparam logic [7:0] PAST_TOP_FILL = 8'hFF;
    localparam logic [7:0] IDLE_FILL = 8'hFF;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam logic [255:0] READ_ONLY_DEFAULT = {8'h88, 248'h0};

    // ------------------------------------------------------------
    // Bit counting
    // ------------------------------------------------------------
    localparam logic [3:0] LSB_BIT_INDEX = 4'h7;
    localparam logic [3:0] ACK_BIT_INDEX = 4'h8;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    // ------------------------------------------------------------
    // Link clock generation
    // ------------------------------------------------------------
    localparam int QUARTER_CYCLES_DEFAULT = 8;
    localparam int QUARTER_CYCLES_MIN = 6;
    localparam int QUARTER_CYCLES_MAX = 256;

    // ------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        T_IDLE,
        T_ADDR,
        T_POINTER,
        T_WDATA,
        T_RDATA,
        T_IGNORE
    } target_state_e;

    typedef enum logic [1:0] {
        C_IDLE,
        C_START,
        C_BIT,
        C_STOP
    } ctl_state_e;

    typedef enum logic [2:0] {
        G_ADDR_W,
        G_POINTER,
        G_WDATA,
        G_ADDR_R,
        G_RDATA
    } ctl_stage_e;

endpackage
`default_nettype wire

//--- include/tw_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tw_link_if;

    logic sclOut;
    logic sclOe;
    logic hostSdaOut;
    logic hostSdaOe;
    logic targetSdaOut;
    logic targetSdaOe;
    logic scl;
    logic sda;

    // ------------------------------------------------------------
    // Open-drain wire resolution with pull-up
    // ------------------------------------------------------------
    assign scl = !(sclOe && !sclOut);
    assign sda = !((hostSdaOe && !hostSdaOut) || (targetSdaOe && !targetSdaOut));

    modport target(
        input scl,
        input sda,
        output targetSdaOut,
        output targetSdaOe
    );

    modport controller(
        input scl,
        input sda,
        output sclOut,
        output sclOe,
        output hostSdaOut,
        output hostSdaOe
    );

endinterface
`default_nettype wire

//--- hw/bit_sync.sv
`timescale 1ns/10ps
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1,
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    if (WIDTH < 1) begin : g_bad
        $error("WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] stage1;

    // ------------------------------------------------------------
    // Two-flop synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= {WIDTH{RESET_LEVEL}};
            dout <= {WIDTH{RESET_LEVEL}};
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end

endmodule // bit_sync
`default_nettype wire

//--- hw/tw_target.sv
// How it works
// - Write: address, pointer, low, high bytes, stop
// - First byte at pointer; pointer steps per byte
// - Target drives data line during its own acknowledges and read data bits
// - Every byte except the last read byte is acknowledged by its receiver
// - Writes beyond top address are dropped
// - Read-only writes dropped; reserved writes land
// - Controller never writes reserved locations
// - Controller ends write with stop or restart
// - Next byte may follow acknowledge immediately
// - Read: pointer write, restart, address with read
// - Target owns data line from address acknowledge
// - Read bytes MSB first, pointer steps per byte
// - Controller no-acknowledge ends read; line released
// - Reads beyond top address return FFh
// - Reserved locations read back undefined data
// - Matching address acknowledged even without data
// - Low byte first; bits MSB first, then acknowledge
// - Fixed seven-bit address compare, acknowledge after direction
`timescale 1ns/10ps
`default_nettype none
module tw_target
    import tw_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDRESS = TARGET_ADDRESS_RESET,
    parameter logic [255:0] READ_ONLY_MAP = READ_ONLY_DEFAULT
) (
    input wire logic clk,
    input wire logic resetn,
    tw_link_if.target link,
    input wire logic [7:0] userAddr,
    output logic [7:0] userData,
    input wire logic loadEn,
    input wire logic [7:0] loadAddr,
    input wire logic [7:0] loadData,
    output logic wrPulse,
    output logic [7:0] wrAddr,
    output logic [7:0] wrData,
    output logic wrDropped,
    output logic busy
);

    typedef struct packed {
        target_state_e state;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] pointer;
        logic pastTop;
        logic ackNow;
        logic sdaLow;
        logic [7:0] txByte;
        logic wrPulse;
        logic wrDropped;
        logic [7:0] wrAddr;
        logic [7:0] wrData;
        logic sclPrev;
        logic sdaPrev;
    } target_s;

    target_s st;
    target_s next_st;
    logic sclS;
    logic sdaS;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic [7:0] rxByte;
    logic [7:0] readByte;
    logic [7:0] mem [0:255];

    // ------------------------------------------------------------
    // Link sampling
    // ------------------------------------------------------------
    bit_sync #(
        .WIDTH(2),
        .RESET_LEVEL(1'b1)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .din({link.scl, link.sda}),
        .dout({sclS, sdaS})
    );

    assign sclRise = sclS && !st.sclPrev;
    assign sclFall = !sclS && st.sclPrev;
    assign startSeen = sclS && st.sclPrev && st.sdaPrev && !sdaS;
    assign stopSeen = sclS && st.sclPrev && !st.sdaPrev && sdaS;
    assign rxByte = {st.shift[6:0], sdaS};
    assign readByte = st.pastTop ? PAST_TOP_FILL : mem[st.pointer];

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.wrPulse = 1'b0;
        next_st.wrDropped = 1'b0;
        next_st.sclPrev = sclS;
        next_st.sdaPrev = sdaS;
        if (startSeen) begin
            // Start and repeated start both reopen address phase
            next_st.state = T_ADDR;
            next_st.bitCnt = 4'h0;
            next_st.sdaLow = 1'b0;
            next_st.ackNow = 1'b0;
        end else if (stopSeen) begin
            next_st.state = T_IDLE;
            next_st.bitCnt = 4'h0;
            next_st.sdaLow = 1'b0;
            next_st.ackNow = 1'b0;
        end else if (st.state != T_IDLE && sclRise) begin
            if (st.bitCnt != ACK_BIT_INDEX) begin
                next_st.shift = rxByte;
                next_st.bitCnt = st.bitCnt + 4'h1;
            end
            if (st.bitCnt == LSB_BIT_INDEX) begin
                unique case (st.state)
                    T_ADDR: begin
                        next_st.ackNow = (rxByte[7:1] == TARGET_ADDRESS);
                    end
                    T_POINTER: begin
                        next_st.pointer = rxByte;
                        next_st.pastTop = 1'b0;
                        next_st.ackNow = 1'b1;
                    end
                    T_WDATA: begin
                        next_st.ackNow = 1'b1;
                        if (!st.pastTop && !READ_ONLY_MAP[st.pointer]) begin
                            next_st.wrPulse = 1'b1;
                            next_st.wrAddr = st.pointer;
                            next_st.wrData = rxByte;
                        end else begin
                            next_st.wrDropped = 1'b1;
                        end
                        if (st.pointer == TOP_ADDRESS) begin
                            next_st.pastTop = 1'b1;
                        end else begin
                            next_st.pointer = st.pointer + 8'h01;
                        end
                    end
                    T_RDATA: begin
                        next_st.ackNow = 1'b0;
                        if (st.pointer == TOP_ADDRESS) begin
                            next_st.pastTop = 1'b1;
                        end else begin
                            next_st.pointer = st.pointer + 8'h01;
                        end
                    end
                    T_IDLE, T_IGNORE: begin
                        next_st.ackNow = 1'b0;
                    end
                endcase
            end
            if (st.bitCnt == ACK_BIT_INDEX) begin
                next_st.bitCnt = 4'h0;
                unique case (st.state)
                    T_ADDR: begin
                        if (!st.ackNow) begin
                            next_st.state = T_IGNORE;
                        end else if (st.shift[0] == DIR_READ) begin
                            next_st.state = T_RDATA;
                            next_st.txByte = readByte;
                        end else begin
                            next_st.state = T_POINTER;
                        end
                    end
                    T_POINTER: begin
                        next_st.state = T_WDATA;
                    end
                    T_RDATA: begin
                        if (sdaS) begin
                            next_st.state = T_IGNORE;
                        end else begin
                            next_st.txByte = readByte;
                        end
                    end
                    T_WDATA, T_IDLE, T_IGNORE: begin
                        next_st.ackNow = 1'b0;
                    end
                endcase
            end
        end else if (st.state != T_IDLE && sclFall) begin
            if (st.bitCnt == ACK_BIT_INDEX) begin
                next_st.sdaLow = st.ackNow && st.state != T_RDATA;
            end else if (st.state == T_RDATA) begin
                next_st.sdaLow = !st.txByte[3'h7 - st.bitCnt[2:0]];
            end else begin
                next_st.sdaLow = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st.state <= T_IDLE;
            st.bitCnt <= 4'h0;
            st.shift <= 8'h00;
            st.pointer <= 8'h00;
            st.pastTop <= 1'b0;
            st.ackNow <= 1'b0;
            st.sdaLow <= 1'b0;
            st.txByte <= IDLE_FILL;
            st.wrPulse <= 1'b0;
            st.wrDropped <= 1'b0;
            st.wrAddr <= 8'h00;
            st.wrData <= 8'h00;
            st.sclPrev <= 1'b1;
            st.sdaPrev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (st.wrPulse) begin
            mem[st.wrAddr] <= st.wrData;
        end else if (loadEn) begin
            mem[loadAddr] <= loadData;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            userData <= 8'h00;
        end else begin
            userData <= mem[userAddr];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.targetSdaOut = 1'b0;
    assign link.targetSdaOe = st.sdaLow;
    assign wrPulse = st.wrPulse;
    assign wrAddr = st.wrAddr;
    assign wrData = st.wrData;
    assign wrDropped = st.wrDropped;
    assign busy = (st.state != T_IDLE);

endmodule // tw_target
`default_nettype wire

//--- hw/tw_controller.sv
`timescale 1ns/10ps
`default_nettype none
module tw_controller
    import tw_pkg::*;
#(
    parameter int QUARTER_CYCLES = QUARTER_CYCLES_DEFAULT,
    parameter logic [6:0] TARGET_ADDRESS = TARGET_ADDRESS_RESET
) (
    input wire logic clk,
    input wire logic resetn,
    tw_link_if.controller link,
    input wire logic go,
    input wire logic readNotWrite,
    input wire logic [7:0] pointerIn,
    input wire logic [7:0] byteCount,
    input wire logic [7:0] txData,
    output logic txTake,
    output logic [7:0] rxData,
    output logic rxValid,
    output logic ackError,
    output logic busy
);

    if (QUARTER_CYCLES < QUARTER_CYCLES_MIN || QUARTER_CYCLES > QUARTER_CYCLES_MAX) begin : g_bad
        $error("QUARTER_CYCLES out of range");
    end

    typedef struct packed {
        ctl_state_e state;
        ctl_stage_e stage;
        logic [1:0] phase;
        logic [7:0] div;
        logic [3:0] bitCnt;
        logic [8:0] tx;
        logic [8:0] rx;
        logic [7:0] remain;
        logic [7:0] pointer;
        logic rw;
        logic sclHigh;
        logic sdaLow;
        logic [7:0] rxData;
        logic rxValid;
        logic txTake;
        logic ackError;
    } ctl_s;

    ctl_s st;
    ctl_s next_st;
    logic sdaS;
    logic tick;
    logic nack;

    bit_sync #(
        .WIDTH(1),
        .RESET_LEVEL(1'b1)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .din(link.sda),
        .dout(sdaS)
    );

    assign tick = (st.div == 8'(QUARTER_CYCLES - 1));
    assign nack = st.rx[0];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rxValid = 1'b0;
        next_st.txTake = 1'b0;
        next_st.div = tick ? 8'h00 : st.div + 8'h01;
        if (st.state == C_IDLE) begin
            next_st.div = 8'h00;
            if (go) begin
                next_st.state = C_START;
                next_st.stage = G_ADDR_W;
                next_st.phase = 2'h0;
                next_st.rw = readNotWrite;
                next_st.pointer = pointerIn;
                next_st.remain = byteCount;
                next_st.ackError = 1'b0;
                next_st.tx = {TARGET_ADDRESS, DIR_WRITE, 1'b1};
            end
        end else if (tick) begin
            next_st.phase = st.phase + 2'h1;
            unique case (st.state)
                C_START: begin
                    unique case (st.phase)
                        2'h0: next_st.sdaLow = 1'b0;
                        2'h1: next_st.sclHigh = 1'b1;
                        2'h2: next_st.sdaLow = 1'b1;
                        2'h3: begin
                            next_st.sclHigh = 1'b0;
                            next_st.state = C_BIT;
                            next_st.bitCnt = 4'h0;
                        end
                    endcase
                end
                C_BIT: begin
                    unique case (st.phase)
                        2'h0: next_st.sdaLow = !st.tx[8];
                        2'h1: next_st.sclHigh = 1'b1;
                        2'h2: next_st.rx = {st.rx[7:0], sdaS};
                        2'h3: begin
                            next_st.sclHigh = 1'b0;
                            next_st.tx = {st.tx[7:0], 1'b1};
                            next_st.bitCnt = st.bitCnt + 4'h1;
                        end
                    endcase
                    if (st.phase == PHASE_LAST && st.bitCnt == ACK_BIT_INDEX) begin
                        next_st.bitCnt = 4'h0;
                        unique case (st.stage)
                            G_ADDR_W: begin
                                if (nack) begin
                                    next_st.ackError = 1'b1;
                                    next_st.state = C_STOP;
                                end else if (st.remain == 8'h00) begin
                                    next_st.state = C_STOP;
                                end else begin
                                    next_st.stage = G_POINTER;
                                    next_st.tx = {st.pointer, 1'b1};
                                end
                            end
                            G_POINTER: begin
                                if (nack) begin
                                    next_st.ackError = 1'b1;
                                    next_st.state = C_STOP;
                                end else if (st.rw == DIR_READ) begin
                                    next_st.stage = G_ADDR_R;
                                    next_st.state = C_START;
                                    next_st.tx = {TARGET_ADDRESS, DIR_READ, 1'b1};
                                end else begin
                                    next_st.stage = G_WDATA;
                                    next_st.tx = {txData, 1'b1};
                                    next_st.txTake = 1'b1;
                                end
                            end
                            G_WDATA: begin
                                next_st.remain = st.remain - 8'h01;
                                if (nack) begin
                                    next_st.ackError = 1'b1;
                                    next_st.state = C_STOP;
                                end else if (st.remain == 8'h01) begin
                                    next_st.state = C_STOP;
                                end else begin
                                    next_st.tx = {txData, 1'b1};
                                    next_st.txTake = 1'b1;
                                end
                            end
                            G_ADDR_R: begin
                                if (nack) begin
                                    next_st.ackError = 1'b1;
                                    next_st.state = C_STOP;
                                end else begin
                                    next_st.stage = G_RDATA;
                                    next_st.tx = {IDLE_FILL, st.remain == 8'h01};
                                end
                            end
                            G_RDATA: begin
                                next_st.rxValid = 1'b1;
                                next_st.rxData = st.rx[8:1];
                                next_st.remain = st.remain - 8'h01;
                                if (st.remain == 8'h01) begin
                                    next_st.state = C_STOP;
                                end else begin
                                    next_st.tx = {IDLE_FILL, st.remain == 8'h02};
                                end
                            end
                        endcase
                    end
                end
                C_STOP: begin
                    unique case (st.phase)
                        2'h0: next_st.sdaLow = 1'b1;
                        2'h1: next_st.sclHigh = 1'b1;
                        2'h2: next_st.sdaLow = 1'b0;
                        2'h3: next_st.state = C_IDLE;
                    endcase
                end
                C_IDLE: next_st.phase = 2'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '{state: C_IDLE, stage: G_ADDR_W, sclHigh: 1'b1, tx: 9'h1FF, rx: 9'h1FF,
                    default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.sclOut = 1'b0;
    assign link.sclOe = !st.sclHigh;
    assign link.hostSdaOut = 1'b0;
    assign link.hostSdaOe = st.sdaLow;
    assign txTake = st.txTake;
    assign rxData = st.rxData;
    assign rxValid = st.rxValid;
    assign ackError = st.ackError;
    assign busy = (st.state != C_IDLE);

endmodule // tw_controller
`default_nettype wire

//--- verification/tw_link_props.sv
`timescale 1ns/10ps
`default_nettype none
module tw_link_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic hostSdaOut,
    input wire logic hostSdaOe,
    input wire logic targetSdaOut,
    input wire logic targetSdaOe,
    input wire logic scl,
    input wire logic sda
);
    // ----------------
    // Low time count
    // ----------------
    logic [7:0] lowCnt;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lowCnt <= 8'h00;
        end else begin
            lowCnt <= scl ? 8'h00 : lowCnt + {7'h00, lowCnt != 8'hFF};
        end
    end
    // ----------------
    // Wire rules
    // ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    tgt_slot_a: assert property ($changed(targetSdaOe) |-> !scl && lowCnt inside {[2:5]})
        else $error("target enable off slot");
    scl_high_a: assert property ($rose(scl) |-> scl [*8])
        else $error("short scl high");
    scl_low_a: assert property ($fell(scl) |-> !scl [*8])
        else $error("short scl low");
    no_stretch_a: assert property (!scl |-> lowCnt < 8'h28)
        else $error("scl held low");
    stop_release_a: assert property (scl && $rose(sda) |-> !targetSdaOe)
        else $error("target holds sda at stop");
    start_release_a: assert property (scl && $fell(sda) |-> !targetSdaOe)
        else $error("target holds sda at start");
    sda_stable_a: assert property (scl && $past(scl) && $changed(sda)
        |-> $changed({hostSdaOe, hostSdaOut})) else $error("sda moved in scl high");
    no_clash_a: assert property (scl && targetSdaOe |-> !hostSdaOe)
        else $error("both ends pull sda");
    drain_only_a: assert property (!sclOut && !hostSdaOut && !targetSdaOut)
        else $error("pin driven high");
    cover property (scl && targetSdaOe);
    cover property (scl && $rose(sda));
    cover property (scl && $fell(sda));
endmodule // tw_link_props
`default_nettype wire

//--- verification/two_wire_register_access_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR t=%0t got %h want %h", $time, a, b); end end
module two_wire_register_access_tb;
    import tw_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, go = 1'b0, rnw = 1'b0, loadEn = 1'b0;
    logic txTake, rxValid, ackError, cBusy, wrPulse, wrDropped, tBusy;
    logic [7:0] ptr = 8'h00, cnt = 8'h00, txData = 8'h00, userAddr = 8'h00, loadAddr = 8'h00;
    logic [7:0] loadData = 8'h00, rxData, userData, wrAddr, wrData, p;
    logic [7:0] mem [256];
    bit known [256];
    logic [7:0] wq[$], rq[$];
    logic [15:0] eq[$];
    logic [15:0] expWr;
    bit rk[$];
    int num_errors = 0, total_checks = 0, dropN = 0, dropE = 0, cycles = 0;
    int seed = 32'h3807C299;
    always #2 clk = ~clk;
    tw_link_if lnk();
    tw_target i_tw_target(.clk(clk), .resetn(resetn), .link(lnk), .userAddr(userAddr),
        .userData(userData), .loadEn(loadEn), .loadAddr(loadAddr), .loadData(loadData),
        .wrPulse(wrPulse), .wrAddr(wrAddr), .wrData(wrData), .wrDropped(wrDropped), .busy(tBusy));
    tw_controller i_tw_controller(.clk(clk), .resetn(resetn), .link(lnk), .go(go),
        .readNotWrite(rnw), .pointerIn(ptr), .byteCount(cnt), .txData(txData), .txTake(txTake),
        .rxData(rxData), .rxValid(rxValid), .ackError(ackError), .busy(cBusy));
    tw_link_props i_tw_link_props(.clk(clk), .resetn(resetn), .sclOut(lnk.sclOut),
        .sclOe(lnk.sclOe), .hostSdaOut(lnk.hostSdaOut), .hostSdaOe(lnk.hostSdaOe),
        .targetSdaOut(lnk.targetSdaOut), .targetSdaOe(lnk.targetSdaOe), .scl(lnk.scl),
        .sda(lnk.sda));
    // ----------------
    // Result monitor
    // ----------------
    always @(negedge clk) begin
        cycles++;
        if (cycles > 60000) begin
            num_errors++;
            tally_and_finish();
        end
        if (wrPulse === 1'b1) begin
            expWr = eq.pop_front();
            `CHK({wrAddr, wrData}, expWr)
        end
        if (wrDropped === 1'b1) dropN++;
        if (rxValid === 1'b1) begin
            if (rk.pop_front()) `CHK(rxData, rq[0])
            void'(rq.pop_front());
        end
    end
    always @(negedge clk) begin
        if (txTake === 1'b1) begin
            void'(wq.pop_front());
            txData <= wq.size() ? wq[0] : 8'h00;
        end
    end
    // ----------------
    // Bus transfer
    // ----------------
    task automatic xfer(input logic r, input logic [7:0] pp, input int n);
        logic [7:0] a, b;
        bit past;
        a = pp;
        past = 1'b0;
        wq.delete();
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            if (r) begin
                rq.push_back(past ? PAST_TOP_FILL : mem[a]);
                rk.push_back(past || known[a]);
            end else begin
                wq.push_back(b);
                if (past || READ_ONLY_DEFAULT[a]) begin
                    dropE++;
                end else begin
                    eq.push_back({a, b});
                    mem[a] = b;
                    known[a] = 1'b1;
                end
            end
            if (a == TOP_ADDRESS) past = 1'b1;
            else a++;
        end
        rnw = r;
        ptr = pp;
        cnt = 8'(n);
        txData = wq.size() ? wq[0] : 8'h00;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        repeat (2) @(negedge clk);
        while (cBusy === 1'b1) @(negedge clk);
        repeat (8) @(negedge clk);
        `CHK(ackError, 1'b0)
        `CHK(tBusy, 1'b0)
        `CHK(eq.size(), 0)
        `CHK(rq.size(), 0)
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        xfer(1'b0, 8'h00, 0);
        $display("test presence done");
        loadEn = 1'b1;
        for (int i = 0; i < 256; i++) begin
            loadAddr = 8'(i);
            loadData = 8'($random(seed));
            mem[loadAddr] = loadData;
            known[loadAddr] = 1'b1;
            @(negedge clk);
        end
        loadEn = 1'b0;
        xfer(1'b0, 8'hF9, 9);
        xfer(1'b1, 8'hF9, 9);
        `CHK(dropN, dropE)
        $display("test top and read-only done");
        repeat (5) begin
            p = 8'($random(seed));
            cnt = 8'h01 + 8'($random(seed) & 7);
            xfer(1'b0, p, int'(cnt));
            xfer(1'b1, p, int'(cnt) + 1);
        end
        $display("test random words done");
        for (int a = 0; a < 256; a++) begin
            if (known[a]) begin
                userAddr = 8'(a);
                @(negedge clk);
                `CHK(userData, mem[a])
            end
        end
        $display("test storage done");
        tally_and_finish();
    end
endmodule // two_wire_register_access_tb
`default_nettype wire
